// >>> fchm_regs.svh
// Constants for the flash card host-mode front end: addresses, sizes, timing.
// Assumes inclusion by fchm_pkg.sv and the design modules; definitions only.
`ifndef FCHM_REGS_SVH
`define FCHM_REGS_SVH

// ************************************************************
// Attribute memory map
// ************************************************************
`define FCHM_CFG_BASE       11'h200
`define FCHM_CFG_BASE_BYTE  8'h02
`define FCHM_CIS_BYTES      256
`define FCHM_CIS_AW         8
`define FCHM_CFG_OPTION     2'h0
`define FCHM_CFG_STATUS     2'h1
`define FCHM_CFG_PIN        2'h2
`define FCHM_CFG_COPY       2'h3
`define FCHM_IDX_MASK       6'h3F
`define FCHM_SRST_BIT       7
`define FCHM_OPT_RST        8'h00
`define FCHM_ADDR_W         11
`define FCHM_IDE_ADDR_W     3

// ************************************************************
// Timing
// ************************************************************
`define FCHM_CLK_MHZ        25
`define FCHM_BUSY_NS        200
`define FCHM_BUSY_CYC       (((`FCHM_BUSY_NS * `FCHM_CLK_MHZ) + 999) / 1000)
`define FCHM_PIO4_CYC_NS    120
`define FCHM_MDMA2_CYC_NS   120
`define FCHM_CYC_MIN        (((`FCHM_PIO4_CYC_NS * `FCHM_CLK_MHZ) + 999) / 1000)

`endif

// >>> fchm_pkg.sv
// Types for the flash card host-mode front end.
// Assumes fchm_regs.svh is on the include path.
`include "fchm_regs.svh"

package fchm_pkg;
    typedef enum logic [1:0] {
        FCHM_MODE_MEM,
        FCHM_MODE_IO,
        FCHM_MODE_IDE
    } fchm_mode_t;

    typedef enum logic [1:0] {
        FCHM_PWR_DOWN,
        FCHM_PWR_WAKE,
        FCHM_PWR_BUSY
    } fchm_pwr_t;
endpackage : fchm_pkg

// >>> fchm_cis_rom.sv
// Card information structure store, 256 bytes of attribute memory.
// Assumes a byte index from the host decoder; read data is registered.
`timescale 1ns/1ps
`include "fchm_regs.svh"

module fchm_cis_rom
    import fchm_pkg::*;
(
    input  wire logic                    sys_clk_i,
    input  wire logic [`FCHM_CIS_AW-1:0] idx_i,
    output logic      [7:0]              data_o
);
    // Table held as constants; the configuration tuple carries the register base
    function automatic logic [7:0] cis_byte(input logic [`FCHM_CIS_AW-1:0] i);
        case (i)
            8'h00:   cis_byte = 8'h01;               // Device tuple
            8'h01:   cis_byte = 8'h03;
            8'h02:   cis_byte = 8'hD9;
            8'h03:   cis_byte = 8'h01;
            8'h04:   cis_byte = 8'hFF;
            8'h05:   cis_byte = 8'h1A;               // Configuration tuple
            8'h06:   cis_byte = 8'h05;
            8'h07:   cis_byte = 8'h01;               // Two-byte base address field
            8'h08:   cis_byte = 8'h03;               // Last entry index
            8'h09:   cis_byte = `FCHM_CFG_BASE_BYTE; // Base address / 100h
            8'h0A:   cis_byte = 8'h00;
            8'h0B:   cis_byte = 8'h0F;               // Four registers present
            8'h0C:   cis_byte = 8'hFF;               // End of chain
            default: cis_byte = 8'hFF;
        endcase
    endfunction : cis_byte

    // (RULE_04) Tuple base matches decoder
    always_ff @(posedge sys_clk_i) begin
        data_o <= cis_byte(idx_i);
    end
endmodule : fchm_cis_rom

// >>> fchm_front.sv
// Host-facing front end: interface mode choice, attribute memory, power-down.
// Assumes host strobes are synchronous to sys_clk_i and the data bus wire
// is resolved outside from data_oe_n_o.
//
// How it works
// (RULE_01) Memory-mapped, I/O-mapped and IDE disk modes are all supported; memory mode passes no command writes to the back end.
// (RULE_02) Card-bus configuration registers start at 200h in attribute memory.
// (RULE_03) A grounded IDE-mode select input puts the card in IDE disk mode.
// (RULE_04) The configuration tuple reports the real configuration register base.
// (RULE_05) A 256-byte card information structure is readable in attribute memory.
// (RULE_06) The card powers down by itself once a command completes.
// (RULE_07) A new command wakes the card, which then processes it normally.
// (RULE_08) All outputs are always driven except the data bus, released unless reading.
// (RULE_09) Strobe cycles as short as PIO mode 4 and multiword DMA mode 2 are accepted.
// (RULE_10) IDE mode decodes only the three low address lines.
// (RULE_11) The upper data byte and high select serve only 16-bit transfers.
// (RULE_12) Card-bus modes decode all eleven address lines, line 10 most significant; the I/O-mode command write decodes only lines 3..0.
// (RULE_13) The IDE select input is sampled at reset and held until the next one.
`timescale 1ns/1ps
`include "fchm_regs.svh"

module fchm_front
    import fchm_pkg::*;
(
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      ide_mode_select_n_i,
    input  wire logic [`FCHM_ADDR_W-1:0]   addr_i,
    input  wire logic                      card_low_byte_select_n_i,
    input  wire logic                      card_high_byte_select_n_i,
    input  wire logic                      attr_select_n_i,
    input  wire logic                      mem_read_n_i,
    input  wire logic                      mem_write_n_i,
    input  wire logic                      io_read_n_i,
    input  wire logic                      io_write_n_i,
    input  wire logic [15:0]               data_i,
    input  wire logic                      cmd_done_i,
    output logic      [15:0]               data_o,
    output logic      [1:0]                data_oe_n_o,
    output logic      [1:0]                mode_o,
    output logic                           power_down_o,
    output logic                           cmd_valid_o,
    output logic      [7:0]                cmd_data_o,
    output logic                           soft_reset_o,
    output logic      [7:0]                config_option_o
);
    // ************************************************************
    // Mode capture
    // ************************************************************
    logic       mode_taken_q;
    fchm_mode_t mode_q;
    logic       cfg_wr;         // Option register write, decoded further down

    // (RULE_13) Latch once after reset
    // (RULE_03) Grounded select gives IDE
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_taken_q <= 1'b0;
            mode_q       <= FCHM_MODE_MEM;
        end else if (!mode_taken_q) begin
            mode_taken_q <= 1'b1;
            mode_q       <= ide_mode_select_n_i ? FCHM_MODE_MEM : FCHM_MODE_IDE;
        end else if (mode_q != FCHM_MODE_IDE && cfg_wr) begin
            // (RULE_01) Option write picks memory or I/O; index zero means memory
            mode_q <= (data_i[5:0] == 6'h00) ? FCHM_MODE_MEM : FCHM_MODE_IO;
        end
    end

    // ************************************************************
    // Strobe edge detection and address decode
    // ************************************************************
    logic       low_sel;
    logic       high_sel;
    logic       rd_lvl;
    logic       wr_lvl;
    logic       wr_q;
    logic       wr_rise;
    logic       attr_hit;
    logic       cfg_hit;
    logic       cis_hit;
    logic       ide_wr;
    logic       io_wr;
    logic [7:0] cis_data;
    logic [7:0] status_q;
    logic [7:0] pin_q;
    logic [7:0] copy_q;

    // (RULE_11) High byte only with its own select
    assign low_sel  = !card_low_byte_select_n_i;
    assign high_sel = !card_high_byte_select_n_i;

    // Card-bus modes read on memory or I/O read strobes; IDE task file via I/O strobes only
    assign rd_lvl = (low_sel || high_sel) &&
                    ((mode_q == FCHM_MODE_IDE) ? !io_read_n_i
                                               : (!mem_read_n_i || !io_read_n_i));
    assign wr_lvl = (low_sel || high_sel) && (!mem_write_n_i || !io_write_n_i);

    // (RULE_12) Full eleven-line decode
    // (RULE_02) Config block at 200h
    assign attr_hit = (mode_q != FCHM_MODE_IDE) && !attr_select_n_i;
    assign cfg_hit  = attr_hit && (addr_i[`FCHM_ADDR_W-1:3] == 8'(`FCHM_CFG_BASE >> 3));
    assign cis_hit  = attr_hit && (addr_i < 11'(`FCHM_CIS_BYTES * 2));

    // (RULE_09) One-cycle edge detect keeps up with a 120 ns strobe cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= wr_lvl;
        end
    end
    assign wr_rise = wr_q && !wr_lvl;   // Data taken at the trailing edge

    assign cfg_wr = wr_rise && cfg_hit
                    && (addr_i[2:1] == `FCHM_CFG_OPTION) && !addr_i[0];
    // (RULE_10) IDE uses A2..A0 only
    assign ide_wr = wr_rise && (mode_q == FCHM_MODE_IDE) && (addr_i[2:0] == 3'h7);
    assign io_wr  = wr_rise && (mode_q == FCHM_MODE_IO) && attr_select_n_i
                    && (addr_i[3:0] == 4'h7);

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            config_option_o <= `FCHM_OPT_RST;
            status_q        <= 8'h00;
            pin_q           <= 8'h00;
            copy_q          <= 8'h00;
            soft_reset_o    <= 1'b0;
        end else begin
            soft_reset_o <= 1'b0;
            if (wr_rise && cfg_hit && !addr_i[0]) begin
                case (addr_i[2:1])
                    `FCHM_CFG_OPTION: begin
                        config_option_o <= data_i[7:0];
                        soft_reset_o    <= data_i[`FCHM_SRST_BIT];
                    end
                    `FCHM_CFG_STATUS: status_q <= data_i[7:0];
                    `FCHM_CFG_PIN:    pin_q    <= data_i[7:0];
                    `FCHM_CFG_COPY:   copy_q   <= data_i[7:0];
                    default:          copy_q   <= copy_q;
                endcase
            end
        end
    end

    // (RULE_05) CIS at even attribute bytes
    fchm_cis_rom u_cis (
        .sys_clk_i (sys_clk_i),
        .idx_i     (addr_i[`FCHM_CIS_AW:1]),
        .data_o    (cis_data)
    );

    // ************************************************************
    // Command capture and power state
    // ************************************************************
    fchm_pwr_t pwr_q;

    // Command register write hands a byte to the back end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_data_o  <= 8'h00;
        end else begin
            cmd_valid_o <= ide_wr || io_wr;
            if (ide_wr || io_wr) begin
                cmd_data_o <= data_i[7:0];
            end
        end
    end

    // Starts powered down: no command pending after reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pwr_q <= FCHM_PWR_DOWN;
        end else begin
            case (pwr_q)
                // (RULE_07) Command wakes the card
                FCHM_PWR_DOWN: if (ide_wr || io_wr) pwr_q <= FCHM_PWR_WAKE;
                FCHM_PWR_WAKE: pwr_q <= FCHM_PWR_BUSY;
                // (RULE_06) Done returns to power-down; a new command wins
                FCHM_PWR_BUSY: if (cmd_done_i && !(ide_wr || io_wr)) pwr_q <= FCHM_PWR_DOWN;
                default:       pwr_q <= FCHM_PWR_DOWN;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            power_down_o <= 1'b1;
            mode_o       <= 2'h0;
        end else begin
            power_down_o <= (pwr_q == FCHM_PWR_DOWN) && !(ide_wr || io_wr);
            mode_o       <= mode_q;
        end
    end

    // ************************************************************
    // Read data and bus release
    // ************************************************************
    logic [7:0] cfg_rd;
    logic [7:0] rd_byte;
    logic       rd_q;

    always_comb begin
        case (addr_i[2:1])
            `FCHM_CFG_OPTION: cfg_rd = config_option_o;
            `FCHM_CFG_STATUS: cfg_rd = status_q;
            `FCHM_CFG_PIN:    cfg_rd = pin_q;
            default:          cfg_rd = copy_q;
        endcase
    end

    // ROM answers one cycle late, so the bus enable lags by the same cycle
    assign rd_byte = cfg_hit ? cfg_rd : (cis_hit ? cis_data : 8'hFF);

    // (RULE_08) Drive only while reading
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_q        <= 1'b0;
            data_o      <= 16'h0000;
            data_oe_n_o <= 2'b11;
        end else begin
            rd_q        <= rd_lvl;
            data_o      <= {8'hFF, rd_byte};
            data_oe_n_o <= {!(rd_q && rd_lvl && high_sel), !(rd_q && rd_lvl && low_sel)};
        end
    end
endmodule : fchm_front

// >>> fchm_front_monitor.sv
// Checker for the flash card host-mode front end, bound to fchm_front.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module fchm_front_monitor
    import fchm_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        ide_mode_select_n_i,
    input wire logic [10:0] addr_i,
    input wire logic        card_low_byte_select_n_i,
    input wire logic        attr_select_n_i,
    input wire logic        mem_read_n_i,
    input wire logic        mem_write_n_i,
    input wire logic        io_read_n_i,
    input wire logic        io_write_n_i,
    input wire logic [15:0] data_i,
    input wire logic        cmd_done_i,
    input wire logic [1:0]  data_oe_n_o,
    input wire logic [1:0]  mode_o,
    input wire logic        power_down_o,
    input wire logic        cmd_valid_o,
    input wire logic [7:0]  cmd_data_o,
    input wire logic        soft_reset_o
);
    // ************************************************************
    // Helpers
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // A read is any selected read strobe, memory or I/O
    wire       rd_any = !card_low_byte_select_n_i && !(mem_read_n_i && io_read_n_i);
    wire       ide    = (mode_o == FCHM_MODE_IDE);
    wire [7:0] wlo    = data_i[7:0];
    wire       wb7    = data_i[7];

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_OE_CAUSE: assert property (data_oe_n_o != 2'h3 |-> $past(rd_any) || $past(rd_any, 2))
        else $error("data bus driven without a read");
    AST_RD_LAT: assert property ($fell(mem_read_n_i) && !attr_select_n_i
        && !card_low_byte_select_n_i && !ide |-> ##2 !data_oe_n_o[0])
        else $error("attribute read not answered two cycles after strobe");
    AST_CMD_TAKE: assert property ($rose(io_write_n_i) && !card_low_byte_select_n_i
        && attr_select_n_i && addr_i == 11'h007 && mode_o != FCHM_MODE_MEM
        |=> cmd_valid_o && cmd_data_o == $past(wlo))
        else $error("command byte not passed on after write");
    AST_CMD_PULSE: assert property (cmd_valid_o |=> !cmd_valid_o)
        else $error("command valid longer than one cycle");
    AST_SLEEP: assert property (cmd_done_i |-> ##[1:2] (power_down_o || cmd_valid_o))
        else $error("no power-down after command completion");
    AST_WAKE: assert property (cmd_valid_o |-> ##[0:2] !power_down_o)
        else $error("command did not wake the card");
    AST_IDE_HOLD: assert property (ide |=> ide)
        else $error("disk mode left without reset");
    AST_IDE_ENTRY: assert property ($fell(rst_i) && !ide_mode_select_n_i |-> ##[1:2] ide)
        else $error("grounded mode select did not give disk mode");
    AST_SRST: assert property ($rose(mem_write_n_i) && !attr_select_n_i && !ide
        && !card_low_byte_select_n_i && addr_i == 11'h200 |=> soft_reset_o == $past(wb7))
        else $error("option write soft reset mismatch");
endmodule : fchm_front_monitor

bind fchm_front fchm_front_monitor fchm_front_monitor_i (.*);

// >>> fchm_host_model.sv
// Host controller model: drives address, selects, strobes and write data.
// Assumes strobes of three cycles low and data released after each cycle.
`timescale 1ns/1ps

module fchm_host_model (
    input  wire logic        sys_clk_i,
    output logic      [10:0] addr_o,
    output logic             ce_n_o,
    output logic             attr_n_o,
    output logic      [3:0]  strb_n_o,
    output logic      [15:0] data_o
);
    // Idle bus at time zero; strobes are {mem rd, mem wr, io rd, io wr}
    initial begin
        {addr_o, data_o} = '0;
        {ce_n_o, attr_n_o, strb_n_o} = 6'h3F;
    end

    // One host access; select and data are held past the strobe's rise
    // both selects move together
    task automatic cyc(input logic attr, io, wr, input logic [10:0] a,
                       input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_o   <= a;
        data_o   <= d;
        ce_n_o   <= 1'b0;
        attr_n_o <= !attr;
        strb_n_o <= ~{!io && !wr, !io && wr, io && !wr, io && wr};
        repeat (3) @(posedge sys_clk_i);
        strb_n_o <= 4'hF;
        @(posedge sys_clk_i);
        ce_n_o   <= 1'b1;
        attr_n_o <= 1'b1;
        data_o   <= ~d; // Released lines must not keep the old value
        repeat (2) @(posedge sys_clk_i);
    endtask : cyc
endmodule : fchm_host_model

// >>> fchm_front_tb_top.sv
// Self-checking testbench for fchm_front with a host model.
// Assumes a 25 MHz clock and that expected values come from the rules.
`timescale 1ns/1ps

module fchm_front_tb_top;
    import fchm_pkg::*;
    logic sys_clk_i = 0, rst_i = 1, ide_mode_select_n_i = 1, cmd_done_i = 0, oe_q = 1;
    logic [10:0] addr_i;
    logic        card_low_byte_select_n_i, card_high_byte_select_n_i, attr_select_n_i;
    logic        mem_read_n_i, mem_write_n_i, io_read_n_i, io_write_n_i;
    logic [15:0] data_i, data_o, d;
    logic [1:0]  data_oe_n_o, mode_o;
    logic        power_down_o, cmd_valid_o, soft_reset_o;
    logic [7:0]  cmd_data_o, config_option_o;
    int          miscompares = 0, n_checks = 0, seed = 49852;
    logic [15:0] exp_rd[$];
    logic [7:0]  exp_cmd[$];

    always #20 sys_clk_i = ~sys_clk_i;
    assign card_high_byte_select_n_i = card_low_byte_select_n_i;

    fchm_host_model fchm_host_model_i (.sys_clk_i, .addr_o(addr_i),
        .ce_n_o(card_low_byte_select_n_i), .attr_n_o(attr_select_n_i),
        .strb_n_o({mem_read_n_i, mem_write_n_i, io_read_n_i, io_write_n_i}),
        .data_o(data_i));
    fchm_front fchm_front_i (.*);

    task automatic chk(input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // Results are matched to the oldest note as they appear
    always @(negedge sys_clk_i) begin
        if (data_oe_n_o[0] === 1'b0 && oe_q && exp_rd.size() > 0)
            chk(data_o, exp_rd.pop_front());
        if (cmd_valid_o === 1'b1)
            chk(16'(cmd_data_o), 16'(exp_cmd.pop_front()));
        oe_q = data_oe_n_o[0];
    end

    // Watchdog: the run needs about 116 cycles
    initial begin
        #(40 * 3000);
        miscompares++;
        wrap_up();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk(16'(mode_o), 16'h0000);
        chk(16'(power_down_o), 16'h0001);
        // Soft reset, then option index 1 selects I/O mode
        fchm_host_model_i.cyc(1, 0, 1, 11'h200, 16'h0080);
        fchm_host_model_i.cyc(1, 0, 1, 11'h200, 16'h0001);
        @(negedge sys_clk_i);
        chk(16'(mode_o), 16'h0001);
        chk(16'(config_option_o), 16'h0001);
        exp_rd.push_back(16'hFF01);
        fchm_host_model_i.cyc(1, 0, 0, 11'h200, 16'h0000);
        exp_rd.push_back(16'hFFFF);
        fchm_host_model_i.cyc(1, 0, 0, 11'h208, 16'h0000);
        exp_rd.push_back(16'hFFFF);
        fchm_host_model_i.cyc(1, 0, 0, 11'h1FE, 16'h0000);
        // Tuple base field sits at even byte 12h and reads 200h / 100h
        exp_rd.push_back(16'hFF02);
        fchm_host_model_i.cyc(1, 0, 0, 11'h012, 16'h0000);
        $display("test config done");
        // Each command wakes the card, completion puts it down again
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            exp_cmd.push_back(d[7:0]);
            fchm_host_model_i.cyc(0, 1, 1, 11'h007, d);
            @(negedge sys_clk_i);
            chk(16'(power_down_o), 16'h0000);
            @(posedge sys_clk_i) cmd_done_i <= 1'b1;
            @(posedge sys_clk_i) cmd_done_i <= 1'b0;
            repeat (2) @(negedge sys_clk_i);
            chk(16'(power_down_o), 16'h0001);
        end
        $display("test power done");
        // Disk mode: grounded select at reset, attribute space ignored
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        ide_mode_select_n_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Mode is latched at the first edge and shows on the pins after the second
        repeat (3) @(negedge sys_clk_i);
        chk(16'(mode_o), 16'h0002);
        fchm_host_model_i.cyc(1, 0, 1, 11'h200, 16'h0005);
        @(negedge sys_clk_i);
        chk(16'(config_option_o), 16'h0000);
        d = 16'($random(seed));
        exp_cmd.push_back(d[7:0]);
        fchm_host_model_i.cyc(0, 1, 1, 11'h007, d);
        @(negedge sys_clk_i);
        chk(16'(mode_o), 16'h0002);
        chk(16'(exp_cmd.size() + exp_rd.size()), 16'h0000);
        $display("test disk mode done");
        wrap_up();
    end
endmodule : fchm_front_tb_top
